// ===== rtl/awcm_pkg.sv
// Notes on behaviour
// - After every finished conversion the result is compared with both limits, no software needed.
// - The window flag can be read by software and is also offered as an interrupt request.
// - With inside detection the flag sets only when greater-than limit < result < less-than limit.
// - With outside detection the flag sets when result < lower bound or result > upper bound.
// - The greater-than limit is a 16-bit value in two readable and writable byte registers.
// - The less-than limit is a 16-bit value in two readable and writable byte registers.
// - Single-ended results compare unsigned, and the justification applies to result and limits.
// - A 5-bit channel field in bits 4:0 picks the converter's positive input.
// - Codes 0x00-0x07 pick port 0 pins, 0x0C-0x0F port 1 pins 4-7, 0x10-0x13 port 2 pins 0-3.
// - Code 0x1B picks temperature, 0x1C and 0x1E battery, 0x1D digital supply, 0x1F ground.
// - Channel register bits 7:5 read as zero and ignore writes.
// - Hardware only sets the window flag; software must clear it explicitly.
// - Shift-justify code 000 gives right justified data and 100 left justified data.
package awcm_pkg;

  localparam logic [7:0] ADDR_INPUT_SELECT = 8'hBB;
  localparam logic [7:0] ADDR_GT_LOW = 8'hC3;
  localparam logic [7:0] ADDR_GT_HIGH = 8'hC4;
  localparam logic [7:0] ADDR_LT_LOW = 8'hC5;
  localparam logic [7:0] ADDR_LT_HIGH = 8'hC6;

  localparam logic [4:0] RST_CHANNEL = 5'h1F;
  localparam logic [7:0] RST_GT_BYTE = 8'hFF;
  localparam logic [7:0] RST_LT_BYTE = 8'h00;

  localparam logic [2:0] SJ_RIGHT = 3'h0;
  localparam logic [2:0] SJ_LEFT = 3'h4;
  localparam int LEFT_SHIFT_10 = 6;

  localparam logic [4:0] CH_PORT0_LO = 5'h00;
  localparam logic [4:0] CH_PORT0_HI = 5'h07;
  localparam logic [4:0] CH_PORT1_LO = 5'h0C;
  localparam logic [4:0] CH_PORT1_HI = 5'h0F;
  localparam logic [4:0] CH_PORT2_LO = 5'h10;
  localparam logic [4:0] CH_PORT2_HI = 5'h13;
  localparam logic [4:0] CH_INTERNAL_LO = 5'h1B;
  localparam logic [4:0] CH_INTERNAL_HI = 5'h1F;
  localparam logic [2:0] CHANNEL_PAD = 3'h0;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  typedef enum logic [2:0] {
    AWCM_SRC_PORT = 3'b001,
    AWCM_SRC_INTERNAL = 3'b010,
    AWCM_SRC_RESERVED = 3'b100
  } awcm_src_t;

endpackage

// ===== rtl/awcm_window_mux.sv
`timescale 1ns/100ps
module awcm_window_mux (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_write_in,
  input wire logic sfr_read_in,
  input wire logic window_flag_clear_in,
  input wire logic conversion_done_in,
  input wire logic [15:0] result_word_in,
  input wire logic [2:0] shift_justify_field_in,
  output logic [7:0] sfr_rdata_out,
  output logic window_match_flag_out,
  output logic window_irq_out,
  output logic [4:0] positive_channel_field_out,
  output logic [2:0] channel_source_out
);

  ////////////////////////////////////////////////////////////////
  // Registered state and next values
  logic [4:0] channel_q;
  logic [4:0] channel_d;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic [15:0] gt_q;
  logic [15:0] gt_d;
  logic [15:0] lt_q;
  logic [15:0] lt_d;
  logic flag_q;
  logic flag_d;
  logic irq_q;
  logic irq_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [15:0] formatted;
  logic match;
  logic flag_set;

  ////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic code_in_range(
    input logic [4:0] code,
    input logic [4:0] first,
    input logic [4:0] last
  );
    code_in_range = (code >= first) && (code <= last);
  endfunction

  // Reserved codes get a class of their own so misuse stays visible
  function automatic awcm_pkg::awcm_src_t classify(input logic [4:0] code);
    logic port_hit;
    logic internal_hit;
    port_hit = code_in_range(code, awcm_pkg::CH_PORT0_LO, awcm_pkg::CH_PORT0_HI)
      || code_in_range(code, awcm_pkg::CH_PORT1_LO, awcm_pkg::CH_PORT1_HI)
      || code_in_range(code, awcm_pkg::CH_PORT2_LO, awcm_pkg::CH_PORT2_HI);
    internal_hit = code_in_range(code, awcm_pkg::CH_INTERNAL_LO,
      awcm_pkg::CH_INTERNAL_HI);
    if (port_hit) begin
      classify = awcm_pkg::AWCM_SRC_PORT;
    end else if (internal_hit) begin
      classify = awcm_pkg::AWCM_SRC_INTERNAL;
    end else begin
      // Only reachable when software ignores the reserved codes
      classify = awcm_pkg::AWCM_SRC_RESERVED;
    end
  endfunction

  // Raw right-justified word brought into result-register format
  function automatic logic [15:0] format_result(
    input logic [15:0] raw,
    input logic [2:0] sj
  );
    if (sj == awcm_pkg::SJ_LEFT) begin
      format_result = raw << awcm_pkg::LEFT_SHIFT_10;
    end else begin
      // Reserved shift codes fall back to plain right justification
      format_result = raw;
    end
  endfunction

  // Unsigned compare; limits are taken as already in the same format
  function automatic logic window_hit(
    input logic [15:0] value,
    input logic [15:0] gt_lim,
    input logic [15:0] lt_lim
  );
    if (gt_lim < lt_lim) begin
      window_hit = (value > gt_lim) && (value < lt_lim);
    end else begin
      window_hit = (value < lt_lim) || (value > gt_lim);
    end
  endfunction

  function automatic logic [15:0] merge_byte(
    input logic [15:0] old_word,
    input logic [7:0] new_byte,
    input logic high_half
  );
    merge_byte = old_word;
    if (high_half) begin
      merge_byte[15:8] = new_byte;
    end else begin
      merge_byte[7:0] = new_byte;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Channel selector
  always_comb begin
    channel_d = channel_q;
    if (sfr_write_in && (sfr_addr_in == awcm_pkg::ADDR_INPUT_SELECT)) begin
      // Upper three data bits dropped on purpose
      channel_d = sfr_wdata_in[4:0];
    end
    src_d = classify(channel_d);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      channel_q <= awcm_pkg::RST_CHANNEL;
      src_q <= awcm_pkg::AWCM_SRC_INTERNAL;
    end else begin
      channel_q <= channel_d;
      src_q <= src_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Limit registers, bytes written independently
  always_comb begin
    gt_d = gt_q;
    lt_d = lt_q;
    if (sfr_write_in) begin
      case (sfr_addr_in)
        awcm_pkg::ADDR_GT_LOW: gt_d = merge_byte(gt_q, sfr_wdata_in, 1'b0);
        awcm_pkg::ADDR_GT_HIGH: gt_d = merge_byte(gt_q, sfr_wdata_in, 1'b1);
        awcm_pkg::ADDR_LT_LOW: lt_d = merge_byte(lt_q, sfr_wdata_in, 1'b0);
        awcm_pkg::ADDR_LT_HIGH: lt_d = merge_byte(lt_q, sfr_wdata_in, 1'b1);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gt_q <= {awcm_pkg::RST_GT_BYTE, awcm_pkg::RST_GT_BYTE};
      lt_q <= {awcm_pkg::RST_LT_BYTE, awcm_pkg::RST_LT_BYTE};
    end else begin
      gt_q <= gt_d;
      lt_q <= lt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Window compare
  // Result input may change freely; only the done cycle is trusted
  always_comb begin
    formatted = format_result(result_word_in, shift_justify_field_in);
    match = window_hit(formatted, gt_q, lt_q);
    flag_set = conversion_done_in && match;
  end

  ////////////////////////////////////////////////////////////////
  // Window flag and interrupt request
  always_comb begin
    flag_d = flag_q;
    if (window_flag_clear_in) begin
      flag_d = 1'b0;
    end
    // Set beats clear so a match in the clear cycle is not lost
    if (flag_set) begin
      flag_d = 1'b1;
    end
    irq_d = flag_d;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_read_in) begin
      case (sfr_addr_in)
        awcm_pkg::ADDR_INPUT_SELECT: rdata_d = {awcm_pkg::CHANNEL_PAD, channel_q};
        awcm_pkg::ADDR_GT_LOW: rdata_d = gt_q[7:0];
        awcm_pkg::ADDR_GT_HIGH: rdata_d = gt_q[15:8];
        awcm_pkg::ADDR_LT_LOW: rdata_d = lt_q[7:0];
        awcm_pkg::ADDR_LT_HIGH: rdata_d = lt_q[15:8];
        default: rdata_d = awcm_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= awcm_pkg::RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign sfr_rdata_out = rdata_q;
  assign window_match_flag_out = flag_q;
  assign window_irq_out = irq_q;
  assign positive_channel_field_out = channel_q;
  assign channel_source_out = src_q;

endmodule

// ===== verification/awcm_adc_model.sv
`timescale 1ns/100ps
module awcm_adc_model (
  input wire logic start_in,
  input wire logic [15:0] code_in,
  output logic done_out,
  output logic [15:0] word_out
);
  // Selected pin taken as analog input, skipped by the crossbar
  // Junk outside the done cycle, so a stale sample is never trusted
  assign done_out = start_in;
  assign word_out = start_in ? code_in : ~code_in;
endmodule

// ===== verification/awcm_properties.sv
`timescale 1ns/100ps
module awcm_properties (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic sfr_write_in,
  input wire logic sfr_read_in,
  input wire logic window_flag_clear_in,
  input wire logic conversion_done_in,
  input wire logic window_match_flag_out,
  input wire logic window_irq_out,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [4:0] positive_channel_field_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_sel; sfr_read_in && !sfr_write_in && sfr_addr_in == 8'hBB; endsequence
  property p_irq; window_irq_out == window_match_flag_out; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_hold; window_match_flag_out && !window_flag_clear_in |=> window_match_flag_out; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_clr; window_flag_clear_in && !conversion_done_in |=> !window_match_flag_out; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_set; !conversion_done_in |=> !$rose(window_match_flag_out); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_sel; s_sel |=> sfr_rdata_out == {3'h0, positive_channel_field_out}; endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_rdh; !sfr_read_in |=> $stable(sfr_rdata_out); endproperty
  a_rdh: assert property (p_rdh) else $error("rdh");
  property p_chs; !sfr_write_in |=> $stable(positive_channel_field_out); endproperty
  a_chs: assert property (p_chs) else $error("chs");
  property p_unm; sfr_read_in && sfr_addr_in == 8'h00 |=> sfr_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unm");
endmodule

// ===== verification/tb_adc_window_compare_mux.sv
`timescale 1ns/100ps
module tb_adc_window_compare_mux;
  logic clk = 0, rst = 1, we = 0, re = 0, clr = 0, go = 0, done, flag, irq;
  logic [7:0] a = 0, d = 0, q;
  logic [15:0] code = 0, word;
  logic [2:0] sj = 0, src;
  logic [4:0] ch;
  int error_cnt = 0, checked = 0, cyc = 0;
  awcm_adc_model i_adc (.start_in(go), .code_in(code), .done_out(done), .word_out(word));
  awcm_window_mux i_dut (.ref_clk_in(clk), .reset_in(rst), .sfr_addr_in(a), .sfr_wdata_in(d),
    .sfr_write_in(we), .sfr_read_in(re), .window_flag_clear_in(clr), .conversion_done_in(done),
    .result_word_in(word), .shift_justify_field_in(sj), .sfr_rdata_out(q),
    .window_match_flag_out(flag), .window_irq_out(irq), .positive_channel_field_out(ch),
    .channel_source_out(src));
  initial forever #2 clk = ~clk;
  task chk(string n, logic [15:0] s, e);
    checked++;
    error_cnt += int'(s !== e);
    if (s !== e) $display("Error %s exp %h seen %h", n, e, s);
  endtask
  task bus(logic w, logic [7:0] x, y);
    @(negedge clk) {a, d, we, re} = {x, y, w, !w};
    @(negedge clk) {we, re} = 0;
  endtask
  task rd(logic [7:0] x, e);
    bus(0, x, 0);
    chk("rdata", q, e);
  endtask
  task conv(logic [15:0] r, logic e);
    @(negedge clk) {code, go} = {r, 1'b1};
    @(negedge clk) {go, clr} = 2'b01;
    chk("flag", flag, e);
    chk("irq", irq, e);
    @(negedge clk) clr = 0;
    chk("clear", flag, 0);
  endtask
  task t_race;
    @(negedge clk) {code, go} = {16'h0041, 1'b1};
    @(negedge clk) clr = 1;
    @(negedge clk) {go, clr} = 2'b00;
    chk("setwin", flag, 1);
  endtask
  task lim(logic [15:0] g, l);
    for (int i = 0; i < 4; i++) bus(1, 8'(8'hC3 + i), i < 2 ? g[8*i+:8] : l[8*i-16+:8]);
  endtask
  task t_reg;
    rd(8'hBB, 8'h1F);
    rd(8'hC3, 8'hFF);
    rd(8'hC6, 8'h00);
    rd(8'h00, 8'h00);
  endtask
  task t_chan;
    for (int c = 0; c < 32; c++) begin
      if (c inside {[8:11], [20:26]}) continue;
      bus(1, 8'hBB, 8'(8'hE0 + c));
      chk("chan", ch, c);
      chk("src", src, c < 8 || c inside {[12:19]} ? 1 : c > 26 ? 2 : 4);
    end
    rd(8'hBB, 8'h1F);
  endtask
  task t_in;
    lim(16'h0040, 16'h0080);
    rd(8'hC5, 8'h80);
    conv(16'h0040, 0);
    conv(16'h0041, 1);
    conv(16'h0080, 0);
  endtask
  task t_out;
    lim(16'h0080, 16'h0040);
    conv(16'h003F, 1);
    conv(16'h0060, 0);
    conv(16'h0081, 1);
  endtask
  task t_left;
    sj = 3'h4;
    lim(16'h1000, 16'h2000);
    conv(16'h0041, 1);
    conv(16'h0080, 0);
  endtask
  initial begin
    #12 rst = 0;
    t_reg;
    t_chan;
    t_in;
    t_out;
    t_left;
    t_race;
    final_report;
  end
  always @(posedge clk) if (++cyc == 2000) begin
    error_cnt++;
    final_report;
  end
  task final_report;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule
bind awcm_window_mux awcm_properties i_chk (.*);
